//--- rtl/wdr_osc_div.sv
// Internal oscillator model: square wave and per-cycle tick from the system clock.
`timescale 1ns/10ps
`include "wdr_defs.svh"

module wdr_osc_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`WDR_OSC_W-1:0] osc_set_resistor_i,
  output logic osc_sq_o,
  output logic osc_tick_o
);

  logic [`WDR_OSC_W-1:0] cnt_reg;
  logic [`WDR_OSC_W-1:0] cnt_next;
  logic sq_reg;
  logic sq_next;
  logic tick_reg;
  logic tick_next;
  logic [`WDR_OSC_W-1:0] half;

  // The resistor code sets the half period; code zero selects the nominal rate.
  assign half = (osc_set_resistor_i == `WDR_OSC_NOMINAL_CODE) ?
                `WDR_OSC_W'(`WDR_OSC_HALF_CYC) : osc_set_resistor_i;

  // Toggle the square wave every half period; tick once per full period.
  always_comb begin
    cnt_next = cnt_reg + `WDR_OSC_W'(1);
    sq_next = sq_reg;
    tick_next = 1'b0;
    if (cnt_reg >= half - `WDR_OSC_W'(1)) begin
      cnt_next = '0;
      sq_next = ~sq_reg;
      tick_next = ~sq_reg;
    end
  end

  // Oscillator state registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      sq_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sq_reg <= sq_next;
      tick_reg <= tick_next;
    end
  end

  assign osc_sq_o = sq_reg;
  assign osc_tick_o = tick_reg;

  // Square wave edges fall exactly at the end of each half period.
  sq_half_period_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(sq_reg) |-> ($past(cnt_reg) >= $past(half) - `WDR_OSC_W'(1)))
    else $error("Square wave edge outside half-period boundary.");

  // With the nominal code the oscillator half period is the nominal count.
  osc_nominal_rate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ($changed(sq_reg) && $past(osc_set_resistor_i) == `WDR_OSC_NOMINAL_CODE)
    |-> ($past(cnt_reg) == `WDR_OSC_W'(`WDR_OSC_HALF_CYC - 1)))
    else $error("Nominal oscillator half period is wrong.");

endmodule

//--- rtl/wdr_top.sv
// Watchdog and power-on reset generator driving a microcontroller reset pin.
//
// Contract
// - Reset output asserted while any source active.
// - Hold reset for power-on delay after power.
// - Supply above or below window forces reset.
// - Watchdog expiry without kick forces reset.
// - Delays counted in internal oscillator cycles.
// - Square wave output at oscillator frequency.
// - Oscillator nominally 120 kHz, resistor adjusts it.
`timescale 1ns/10ps
`include "wdr_defs.svh"

module wdr_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [`WDR_OSC_W-1:0] osc_set_resistor_i,
  input wire logic vcc_high_i,
  input wire logic vcc_low_i,
  input wire logic watchdog_kick_in_i,
  output logic mcu_rst_n_o,
  output logic osc_sq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser and supply decode.
  ////////////////////////////////////////////////////////////////////////////

  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Release the external reset through two flops; assertion stays asynchronous.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= `WDR_SYNC_CLEAR;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], `WDR_SYNC_SHIFT_IN};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // True when the logic supply is outside its window, high or low.
  function automatic logic wdr_supply_fault(input logic hi, input logic lo);
    wdr_supply_fault = hi | lo;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator.
  ////////////////////////////////////////////////////////////////////////////

  logic osc_tick;

  // The oscillator sets the time base of every delay and drives the square wave.
  wdr_osc_div u_osc (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .osc_set_resistor_i(osc_set_resistor_i),
    .osc_sq_o(osc_sq_o),
    .osc_tick_o(osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor state machine.
  ////////////////////////////////////////////////////////////////////////////

  wdr_pkg::wdr_state_e state_reg;
  wdr_pkg::wdr_state_e state_next;
  logic [`WDR_CNT_W-1:0] cnt_reg;
  logic [`WDR_CNT_W-1:0] cnt_next;
  logic kick_prev_reg;
  logic kick_prev_next;
  logic mcu_rst_n_reg;
  logic mcu_rst_n_next;
  logic fault;
  logic kick_edge;

  assign fault = wdr_supply_fault(vcc_high_i, vcc_low_i);
  assign kick_edge = watchdog_kick_in_i ^ kick_prev_reg;

  // Next state: a supply fault always returns to the power-on delay, so the
  // controller gets a full start-up time once the supply is good again.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    kick_prev_next = watchdog_kick_in_i;
    case (state_reg)
      wdr_pkg::WDR_POR: begin
        if (fault) begin
          cnt_next = `WDR_CNT_ZERO;
        end else if (osc_tick) begin
          if (cnt_reg == `WDR_POR_OSC_CYC - `WDR_CNT_ONE) begin
            state_next = wdr_pkg::WDR_RUN;
            cnt_next = `WDR_CNT_ZERO;
          end else begin
            cnt_next = cnt_reg + `WDR_CNT_ONE;
          end
        end
      end
      wdr_pkg::WDR_RUN: begin
        if (fault) begin
          state_next = wdr_pkg::WDR_POR;
          cnt_next = `WDR_CNT_ZERO;
        end else if (kick_edge) begin
          // Either edge of the kick restarts the count; a square-wave kick
          // therefore keeps the watchdog from ever expiring.
          cnt_next = `WDR_CNT_ZERO;
        end else if (osc_tick) begin
          if (cnt_reg == `WDR_WD_OSC_CYC - `WDR_CNT_ONE) begin
            state_next = wdr_pkg::WDR_PULSE;
            cnt_next = `WDR_CNT_ZERO;
          end else begin
            cnt_next = cnt_reg + `WDR_CNT_ONE;
          end
        end
      end
      wdr_pkg::WDR_PULSE: begin
        if (fault) begin
          state_next = wdr_pkg::WDR_POR;
          cnt_next = `WDR_CNT_ZERO;
        end else if (osc_tick) begin
          if (cnt_reg == `WDR_PULSE_OSC_CYC - `WDR_CNT_ONE) begin
            state_next = wdr_pkg::WDR_RUN;
            cnt_next = `WDR_CNT_ZERO;
          end else begin
            cnt_next = cnt_reg + `WDR_CNT_ONE;
          end
        end
      end
      default: begin
        state_next = wdr_pkg::WDR_POR;
        cnt_next = `WDR_CNT_ZERO;
      end
    endcase
    // Reset is released only in the run state.
    mcu_rst_n_next = (state_next == wdr_pkg::WDR_RUN);
  end

  // Supervisor registers; reset output is low throughout reset.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= wdr_pkg::WDR_POR;
      cnt_reg <= `WDR_CNT_ZERO;
      kick_prev_reg <= 1'b0;
      mcu_rst_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      kick_prev_reg <= kick_prev_next;
      mcu_rst_n_reg <= mcu_rst_n_next;
    end
  end

  assign mcu_rst_n_o = mcu_rst_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////

  // Reset output is released exactly when the supervisor is running.
  rst_follows_state_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    mcu_rst_n_o == (state_reg == wdr_pkg::WDR_RUN))
    else $error("Reset output does not match supervisor state.");

  // Leaving the power-on delay happens only after its full count.
  por_delay_full_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state_reg == wdr_pkg::WDR_RUN && $past(state_reg) == wdr_pkg::WDR_POR)
    |-> ($past(cnt_reg) == `WDR_POR_OSC_CYC - `WDR_CNT_ONE && $past(osc_tick)))
    else $error("Power-on delay ended early.");

  // A supply fault holds the controller in reset on the next cycle.
  supply_fault_reset_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wdr_supply_fault(vcc_high_i, vcc_low_i) |=> !mcu_rst_n_o)
    else $error("Supply fault did not force reset.");

  // An unkicked timeout enters the reset pulse on the next cycle.
  wd_expiry_reset_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state_reg == wdr_pkg::WDR_RUN && osc_tick && !kick_edge && !fault &&
     cnt_reg == `WDR_WD_OSC_CYC - `WDR_CNT_ONE)
    |=> (state_reg == wdr_pkg::WDR_PULSE && !mcu_rst_n_o))
    else $error("Watchdog timeout did not force reset.");

  // The delay counter only advances on an oscillator tick.
  count_on_tick_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (cnt_reg != `WDR_CNT_ZERO && cnt_reg != $past(cnt_reg))
    |-> ($past(osc_tick) && cnt_reg == $past(cnt_reg) + `WDR_CNT_ONE))
    else $error("Delay counter moved without an oscillator tick.");

  // A kick edge in the run state clears the watchdog count.
  kick_restart_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state_reg == wdr_pkg::WDR_RUN && kick_edge && !fault)
    |=> (cnt_reg == `WDR_CNT_ZERO && state_reg == wdr_pkg::WDR_RUN))
    else $error("Kick edge did not restart the watchdog.");

  // The timeout reset pulse lasts its full count before resuming.
  pulse_length_a: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state_reg == wdr_pkg::WDR_RUN && $past(state_reg) == wdr_pkg::WDR_PULSE)
    |-> ($past(cnt_reg) == `WDR_PULSE_OSC_CYC - `WDR_CNT_ONE))
    else $error("Watchdog reset pulse has the wrong length.");

endmodule

//--- shared/wdr_defs.svh
// Timing and width constants for the watchdog reset generator.
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH

// System clock rate in hertz.
`define WDR_CLK_FREQ_HZ 100000000
// Nominal internal oscillator rate in hertz.
`define WDR_OSC_FREQ_HZ 120000
// Nominal oscillator half period in system clock cycles (rounded down).
`define WDR_OSC_HALF_CYC (`WDR_CLK_FREQ_HZ / (2 * `WDR_OSC_FREQ_HZ))
// Width of the oscillator half-period code set by the resistor.
`define WDR_OSC_W 10
// Oscillator half-period code that selects the nominal rate.
`define WDR_OSC_NOMINAL_CODE 10'h000

// Width of the oscillator cycle counter.
`define WDR_CNT_W 16
// Counter value after a restart.
`define WDR_CNT_ZERO 16'h0000
// Counter increment.
`define WDR_CNT_ONE 16'h0001
// Power-on delay in oscillator cycles.
`define WDR_POR_OSC_CYC 16'h0400
// Watchdog timeout in oscillator cycles.
`define WDR_WD_OSC_CYC 16'h0800
// Reset pulse after a watchdog timeout, in oscillator cycles.
`define WDR_PULSE_OSC_CYC 16'h0040

// Reset synchroniser values.
`define WDR_SYNC_CLEAR 2'h0
`define WDR_SYNC_SHIFT_IN 1'h1

`endif

//--- shared/wdr_pkg.sv
// Types shared by the watchdog reset generator.
package wdr_pkg;

  // Supervisor states, Gray coded along power-on, run, timeout pulse.
  typedef enum logic [1:0] {
    WDR_POR   = 2'h0,
    WDR_RUN   = 2'h1,
    WDR_PULSE = 2'h3
  } wdr_state_e;

endpackage

//--- tb/test_wdr_top.sv
// Self-checking bench for the watchdog reset generator.
`timescale 1ns/10ps
`include "wdr_defs.svh"

module test_wdr_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic vcc_high_i = 1'b0;
  logic vcc_low_i = 1'b0;
  logic run = 1'b0;
  logic tie = 1'b0;
  logic kick_q = 1'b0;
  logic [`WDR_OSC_W-1:0] code = 10'h002;
  logic [15:0] gap = 16'h03E7;
  logic kick;
  logic mcu_rst_n;
  logic osc_sq;
  int bad_count = 0;
  int n_checks = 0;
  int since_kick = 0;
  int per;

  always #5 clk_i = ~clk_i;

  wdr_top u_wdr_top (.clk_i(clk_i), .nrst_i(nrst_i), .osc_set_resistor_i(code),
    .vcc_high_i(vcc_high_i), .vcc_low_i(vcc_low_i), .watchdog_kick_in_i(kick),
    .mcu_rst_n_o(mcu_rst_n), .osc_sq_o(osc_sq));
  wdr_mcu_model u_wdr_mcu_model (.clk_i(clk_i), .rst_n_i(mcu_rst_n), .osc_sq_i(osc_sq),
    .run_i(run), .tie_i(tie), .gap_i(gap), .kick_o(kick));

  // Cycles since the last kick edge.
  always @(posedge clk_i) begin
    kick_q <= kick;
    since_kick <= (kick !== kick_q) ? 0 : since_kick + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares a cycle count within a tolerance.
  task chk_n(string what, int exp, int got, int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
      bad_count++;
    end
  endtask

  // Waits a bounded time for the reset output to reach a level.
  task wait_rst(logic lvl, int lim, output int n);
    n = 0;
    while (mcu_rst_n !== lvl) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        $display("unexpected reset level expected %0d seen timeout", lvl);
        bad_count++;
        end_sim();
      end
    end
  endtask

  // Checks that the reset output is driven low; an unknown level is a mismatch.
  task chk_low(string what);
    n_checks++;
    if (mcu_rst_n !== 1'b0) begin
      $display("unexpected %s expected 0 seen %b", what, mcu_rst_n);
      bad_count++;
    end
  endtask

  // Measures one square-wave period between rising edges; a stuck wave ends the run.
  task meas_period(int lim, output int n);
    int w;
    w = 0;
    while (osc_sq !== 1'b0 && w < lim) begin @(posedge clk_i); w++; end
    while (osc_sq !== 1'b1 && w < lim) begin @(posedge clk_i); w++; end
    n = 0;
    @(posedge clk_i);
    while (osc_sq !== 1'b0 && n < lim) begin @(posedge clk_i); n++; end
    while (osc_sq !== 1'b1 && n < lim) begin @(posedge clk_i); n++; end
    n++;
    if (w >= lim || n > lim) begin
      $display("unexpected square wave edge expected toggle seen timeout");
      bad_count++;
      end_sim();
    end
  endtask

  // Counts cycles with the reset output low over a span.
  task count_low(int span, output int lows);
    lows = 0;
    repeat (span) begin
      @(posedge clk_i);
      if (mcu_rst_n !== 1'b1) lows++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on delay and square wave period.
  task t_power;
    int n;
    @(posedge clk_i) nrst_i <= 1'b1;
    wait_rst(1'b1, 40000, n);
    chk_n("power-on delay", `WDR_POR_OSC_CYC * per, n, 2 * per + 4);
    wait_rst(1'b1, 10, n);
    meas_period(100, n);
    chk_n("square period", per, n, 0);
  endtask

  // The nominal resistor code gives the nominal oscillator rate.
  task t_nominal;
    int n;
    @(posedge clk_i) code <= `WDR_OSC_NOMINAL_CODE;
    meas_period(2000, n);
    chk_n("nominal square period", 2 * `WDR_OSC_HALF_CYC, n, 0);
  endtask

  // Regular kicks keep reset released over several timeouts.
  task t_kick;
    int lows;
    @(posedge clk_i) run <= 1'b1;
    count_low(20000, lows);
    chk_n("low cycles while kicked", 0, lows, 0);
  endtask

  // Stopped kicks give a timeout and a reset pulse.
  task t_timeout;
    int n;
    @(posedge clk_i) run <= 1'b0;
    wait_rst(1'b0, 20000, n);
    chk_n("watchdog timeout", `WDR_WD_OSC_CYC * per, since_kick, 2 * per + 4);
    wait_rst(1'b1, 2000, n);
    chk_n("reset pulse", `WDR_PULSE_OSC_CYC * per, n, per + 4);
  endtask

  // Kick tied to the square wave never times out.
  task t_tie;
    int lows;
    @(posedge clk_i) tie <= 1'b1;
    count_low(20000, lows);
    chk_n("low cycles with tied kick", 0, lows, 0);
  endtask

  // Supply above and below the window, both delays after the fault at a slower oscillator.
  task t_fault;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      if (i == 0) vcc_high_i <= 1'b1;
      else vcc_low_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_low("reset on supply fault");
      repeat (50) @(posedge clk_i);
      chk_low("reset held in fault");
      vcc_high_i <= 1'b0;
      vcc_low_i <= 1'b0;
      code <= 10'h004;
      per = 8;
      wait_rst(1'b1, 80000, n);
      chk_n("delay after fault", `WDR_POR_OSC_CYC * per, n, 2 * per + 8);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    per = 2 * int'(code);
    repeat (16) @(posedge clk_i);
    t_power();
    t_kick();
    t_timeout();
    t_tie();
    t_fault();
    t_nominal();
    end_sim();
  end
endmodule

//--- tb/wdr_mcu_model.sv
// Behavioural microcontroller that toggles the watchdog kick input.
`timescale 1ns/10ps

module wdr_mcu_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic osc_sq_i,
  input wire logic run_i,
  input wire logic tie_i,
  input wire logic [15:0] gap_i,
  output logic kick_o
);
  logic [15:0] cnt_reg = 16'h0000;
  logic lvl_reg = 1'b0;

  // Toggle the kick level every gap_i plus one cycles while running and out of reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == gap_i) begin
      cnt_reg <= 16'h0000;
      lvl_reg <= ~lvl_reg;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Tying the kick to the square wave stands in for a board strap.
  assign kick_o = tie_i ? osc_sq_i : lvl_reg;
endmodule
